// File: hdl/edge_separation_encoder_counter.sv
// Edge separation and encoder position counter channel with a
// Wishbone classic register slave.
// Assumes asynchronous terminal pins and a 40 MHz system clock that
// also serves as the internal counter timebase.
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module edge_separation_encoder_counter
  import esec_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [TERM_N-1:0] programmable_function_terminal_i
);

  // ************************************************************
  // State and declarations
  // ************************************************************
  // Every flip-flop of the core lives in this one structure.
  typedef struct packed {
    logic [TERM_N-1:0] sync1; // First synchroniser stage.
    logic [TERM_N-1:0] sync2; // Second synchroniser stage.
    logic [7:0] prev; // Selected signals one cycle ago.
    run_state_t st; // Phase of the run.
    logic [31:0] ctrl; // Control register.
    logic [31:0] select; // Terminal select register.
    logic [CNT_W-1:0] init_val; // Initial position.
    logic [CNT_W-1:0] reload_val; // Index reload value.
    logic [CNT_W-1:0] interval; // Running interval count.
    logic [CNT_W-1:0] result; // Held on-demand interval.
    logic [CNT_W-1:0] last_int; // Latest completed interval.
    logic [CNT_W-1:0] count; // Position count.
    logic res_valid; // A held interval waits for a read.
    logic last_valid; // last_int holds a real interval.
    logic overflow; // Sticky lost-result flag.
    logic ack; // Bus acknowledge.
    logic [31:0] rdata; // Bus read data.
  } core_state_t;

  core_state_t s_reg; // Registered state.
  core_state_t s_next; // Next state.
  logic [7:0] cur; // Selected, synchronised signals now.
  logic [7:0] rise; // Rising edge on each selected signal.
  logic [7:0] fall; // Falling edge on each selected signal.
  logic start_e; // Active start edge.
  logic stop_e; // Active stop edge.
  logic arm_e; // Active arm_trigger edge.
  logic smp_e; // Active sample clock edge.
  logic tick; // One counter timebase tick.
  logic q_up; // Quadrature edge that means phase A leads.
  logic q_dn; // Quadrature edge that means phase B leads.
  logic step_up; // Position counts up this cycle.
  logic step_dn; // Position counts down this cycle.
  logic reload; // Index reload condition holds.
  logic ovf_ev; // A result was refused by a full buffer.
  logic req; // A new bus request stands.
  logic [31:0] wval; // Write data merged by byte enables.
  logic [31:0] cur_reg; // Register addressed by the bus.
  logic [CNT_W-1:0] done_int; // Interval finished this cycle.
  logic sep_mode; // Separation mode selected.
  logic [1:0] timing; // Timing type.
  logic [1:0] decode; // Decoding type.

  result_buf_if #(.W(CNT_W)) rb ();

  // Results are buffered for the implicit and sample clock timings.
  result_buf #(
    .W(CNT_W),
    .DEPTH(DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(rb.buffer)
  );

  assign dat_o = s_reg.rdata;
  assign ack_o = s_reg.ack;

  // ************************************************************
  // Input selection and edge detection
  // ************************************************************
  // Each logical signal picks its pin after two synchroniser stages.
  // Changing a select while running can fake one edge; reselect only
  // while the channel is stopped.
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      cur[k] = s_reg.sync2[s_reg.select[k*SEL_W +: SEL_W]];
    end
  end
  assign rise = cur & ~s_reg.prev;
  assign fall = ~cur & s_reg.prev;
  assign sep_mode = ~s_reg.ctrl[CTRL_MODE];
  assign timing = s_reg.ctrl[CTRL_TIMING +: 2];
  assign decode = s_reg.ctrl[CTRL_DECODE +: 2];

  // Edge polarity of start and stop defaults to rising.
  assign start_e = s_reg.ctrl[CTRL_START_POL] ? fall[SIG_START]
                                              : rise[SIG_START];
  assign stop_e = s_reg.ctrl[CTRL_STOP_POL] ? fall[SIG_STOP]
                                            : rise[SIG_STOP];
  assign arm_e = s_reg.ctrl[CTRL_ARM_POL] ? fall[SIG_ARM]
                                          : rise[SIG_ARM];
  assign smp_e = s_reg.ctrl[CTRL_SMP_POL] ? fall[SIG_SMP]
                                          : rise[SIG_SMP];
  // Internal timebase is every clock; external is each rising edge.
  assign tick = s_reg.ctrl[CTRL_TB_EXT] ? rise[SIG_TB] : 1'b1;

  // ************************************************************
  // Encoder decoding
  // ************************************************************
  // An edge with A leading: A rises with B low, A falls with B high,
  // B rises with A high, B falls with A low.
  always_comb begin
    q_up = 1'b0;
    q_dn = 1'b0;
    step_up = 1'b0;
    step_dn = 1'b0;
    q_up = (rise[SIG_A] & ~cur[SIG_B]) | (fall[SIG_A] & cur[SIG_B]);
    q_dn = (rise[SIG_A] & cur[SIG_B]) | (fall[SIG_A] & ~cur[SIG_B]);
    case (decode)
      DEC_TWO_PULSE: begin
        step_up = rise[SIG_A];
        step_dn = rise[SIG_B];
      end
      DEC_SINGLE: begin
        step_up = rise[SIG_A] & ~cur[SIG_B];
        step_dn = fall[SIG_A] & ~cur[SIG_B];
      end
      DEC_DOUBLE: begin
        step_up = q_up;
        step_dn = q_dn;
      end
      default: begin
        step_up = q_up | (rise[SIG_B] & cur[SIG_A]) |
                  (fall[SIG_B] & ~cur[SIG_A]);
        step_dn = q_dn | (rise[SIG_B] & ~cur[SIG_A]) |
                  (fall[SIG_B] & cur[SIG_A]);
      end
    endcase
  end

  // Index high while A and B match the chosen phase levels.
  assign reload = s_reg.ctrl[CTRL_INDEX_EN] & cur[SIG_INDEX] &
                  (cur[SIG_A] == s_reg.ctrl[CTRL_INDEX_PH + 1]) &
                  (cur[SIG_B] == s_reg.ctrl[CTRL_INDEX_PH]);

  // Interval that ends now includes the tick of this very cycle.
  assign done_int = s_reg.interval + CNT_W'(tick);
  assign req = cyc_i & stb_i & ~s_reg.ack;

  // Byte enables merge write data onto the addressed register.
  always_comb begin
    cur_reg = 32'h0000_0000;
    if (adr_i == CTRL_OFS) begin
      cur_reg = s_reg.ctrl;
    end else if (adr_i == SELECT_OFS) begin
      cur_reg = s_reg.select;
    end else if (adr_i == INIT_OFS) begin
      cur_reg = s_reg.init_val;
    end else if (adr_i == RELOAD_OFS) begin
      cur_reg = s_reg.reload_val;
    end
    for (int b = 0; b < 4; b++) begin
      wval[b*8 +: 8] = sel_i[b] ? dat_i[b*8 +: 8] : cur_reg[b*8 +: 8];
    end
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // The measurement engine acts first; bus writes act afterwards so
  // that a software start or stop wins over the engine in one cycle.
  always_comb begin
    s_next = s_reg;
    s_next.sync1 = programmable_function_terminal_i;
    s_next.sync2 = s_reg.sync1;
    s_next.prev = cur;
    s_next.ack = 1'b0;
    rb.push_valid = 1'b0;
    rb.push_data = '0;
    rb.pop_ready = 1'b0;
    rb.flush = 1'b0;
    case (s_reg.st)
      RUN_ARMING: begin
        // Leave arming on the arm_trigger edge.
        if (arm_e) begin
          s_next.st = sep_mode ? RUN_WAIT_START : RUN_COUNTING;
        end
      end
      RUN_WAIT_START: begin
        // The interval opens on the active start edge.
        if (start_e) begin
          s_next.interval = '0;
          s_next.st = RUN_COUNTING;
        end
      end
      RUN_COUNTING: begin
        if (sep_mode) begin
          // Tick counting wraps at the counter width.
          s_next.interval = done_int;
          if (stop_e) begin
            if (timing == TIM_IMPLICIT) begin
              rb.push_valid = 1'b1;
              rb.push_data = done_int;
            end else if (timing == TIM_SAMPLE) begin
              s_next.last_int = done_int;
              s_next.last_valid = 1'b1;
            end else begin
              s_next.result = done_int;
              s_next.res_valid = 1'b1;
              s_next.st = RUN_HOLD;
            end
            // A start in the same cycle opens the next interval so
            // that back-to-back pairs leave no gap.
            if (timing != TIM_ON_DEMAND && timing != 2'h3) begin
              s_next.interval = '0;
              s_next.st = start_e ? RUN_COUNTING : RUN_WAIT_START;
            end
          end
        end else begin
          // Step first, then a reload overrides it.
          if (step_up && !step_dn) begin
            s_next.count = s_reg.count + CNT_W'(1);
          end else if (step_dn && !step_up) begin
            s_next.count = s_reg.count - CNT_W'(1);
          end
          // Reload lands one clock after the phase is seen.
          if (reload) begin
            s_next.count = s_reg.reload_val;
          end
        end
      end
      default: begin
        // Stopped or holding: inputs are ignored.
      end
    endcase
    // Sample clock timing pushes one result per active edge past arming; separation mode needs a finished interval.
    if (smp_e && timing == TIM_SAMPLE && s_reg.st != RUN_STOPPED &&
        s_reg.st != RUN_ARMING) begin
      if (sep_mode && s_reg.last_valid) begin
        rb.push_valid = 1'b1;
        rb.push_data = s_reg.last_int;
      end else if (!sep_mode) begin
        rb.push_valid = 1'b1;
        rb.push_data = s_reg.count;
      end
    end
    // A refused push is lost and flagged.
    ovf_ev = rb.push_valid & ~rb.push_ready;

    // Wishbone classic: one wait state, ack for one cycle.
    if (req) begin
      s_next.ack = 1'b1;
      s_next.rdata = 32'h0000_0000;
      if (we_i) begin
        if (adr_i == CTRL_OFS) begin
          s_next.ctrl = wval;
          if (wval[CTRL_RUN] && !s_reg.ctrl[CTRL_RUN]) begin
            // Software start presets and launches the run.
            s_next.count = s_reg.init_val;
            s_next.interval = '0;
            s_next.res_valid = 1'b0;
            s_next.last_valid = 1'b0;
            rb.flush = 1'b1;
            if (wval[CTRL_ARM_EN]) begin
              s_next.st = RUN_ARMING;
            end else if (!wval[CTRL_MODE]) begin
              s_next.st = RUN_WAIT_START;
            end else begin
              s_next.st = RUN_COUNTING;
            end
          end else if (!wval[CTRL_RUN]) begin
            s_next.st = RUN_STOPPED;
          end
        end else if (adr_i == SELECT_OFS) begin
          s_next.select = wval;
        end else if (adr_i == INIT_OFS) begin
          s_next.init_val = wval;
        end else if (adr_i == RELOAD_OFS) begin
          s_next.reload_val = wval;
        end else if (adr_i == STATUS_OFS) begin
          if (sel_i[0] && dat_i[ST_OVF]) begin
            s_next.overflow = 1'b0;
          end
        end
      end else begin
        if (adr_i == CTRL_OFS) begin
          s_next.rdata = s_reg.ctrl;
        end else if (adr_i == SELECT_OFS) begin
          s_next.rdata = s_reg.select;
        end else if (adr_i == INIT_OFS) begin
          s_next.rdata = s_reg.init_val;
        end else if (adr_i == RELOAD_OFS) begin
          s_next.rdata = s_reg.reload_val;
        end else if (adr_i == DATA_OFS) begin
          if (timing == TIM_IMPLICIT || timing == TIM_SAMPLE) begin
            // Buffered results come out in order; empty reads zero.
            s_next.rdata = rb.pop_valid ? rb.pop_data : '0;
            rb.pop_ready = 1'b1;
          end else if (sep_mode) begin
            s_next.rdata = s_reg.result;
            // Reading the held interval releases the channel.
            if (s_reg.st == RUN_HOLD) begin
              s_next.st = RUN_WAIT_START;
              s_next.res_valid = 1'b0;
            end
          end else begin
            s_next.rdata = s_reg.count;
          end
        end else if (adr_i == STATUS_OFS) begin
          s_next.rdata[ST_RUNNING] = (s_reg.st != RUN_STOPPED);
          s_next.rdata[ST_HELD] = s_reg.res_valid;
          s_next.rdata[ST_BUF_NE] = rb.pop_valid;
          s_next.rdata[ST_OVF] = s_reg.overflow;
          s_next.rdata[ST_ARMING] = (s_reg.st == RUN_ARMING);
        end else if (adr_i == COUNT_OFS) begin
          s_next.rdata = sep_mode ? s_reg.interval : s_reg.count;
        end
      end
    end
    // A new overflow beats a clear in the same cycle.
    if (ovf_ev) begin
      s_next.overflow = 1'b1;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Synchronous reset to constants; configuration takes defaults.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.st <= RUN_STOPPED;
      s_reg.ctrl <= CTRL_RST;
      s_reg.select <= SELECT_RST;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // edge_separation_encoder_counter
`default_nettype wire

// File: hdl/esec_pkg.sv
// Package of constants and types for the edge separation / encoder counter.
// Assumes a Wishbone classic slave with 32-bit data and byte addresses.
package esec_pkg;

  // ************************************************************
  // Clock and timebase figures
  // ************************************************************
  localparam int unsigned CLK_HZ = 40_000_000; // System clock rate.
  // Internal timebase rate; it is stood in for by the system clock.
  localparam int unsigned TIMEBASE_INT_HZ = 100_000_000;
  localparam int unsigned CNT_W = 32; // Interval and position width.
  localparam int unsigned TERM_N = 8; // Number of terminal pins.
  localparam int unsigned FIFO_DEPTH = 16; // Result buffer depth.

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00; // Mode and run control.
  localparam logic [7:0] SELECT_OFS = 8'h04; // Terminal selects.
  localparam logic [7:0] INIT_OFS = 8'h08; // Initial position.
  localparam logic [7:0] RELOAD_OFS = 8'h0C; // Index reload value.
  localparam logic [7:0] DATA_OFS = 8'h10; // Read request port.
  localparam logic [7:0] STATUS_OFS = 8'h14; // Status and overflow.
  localparam logic [7:0] COUNT_OFS = 8'h18; // Live counter value.

  // ************************************************************
  // Control register fields and reset values
  // ************************************************************
  localparam int CTRL_RUN = 0; // Software start while set.
  localparam int CTRL_MODE = 1; // 0 separation, 1 position.
  localparam int CTRL_TIMING = 2; // Two bits of timing type.
  localparam int CTRL_DECODE = 4; // Two bits of decoding type.
  localparam int CTRL_START_POL = 6; // start_edge_polarity, 1 falling.
  localparam int CTRL_STOP_POL = 7; // stop_edge_polarity, 1 falling.
  localparam int CTRL_ARM_EN = 8; // Wait for arm_trigger.
  localparam int CTRL_ARM_POL = 9; // arm_trigger edge, 1 falling.
  localparam int CTRL_INDEX_EN = 10; // Index reload enable.
  localparam int CTRL_INDEX_PH = 11; // Two bits: B level, A level.
  localparam int CTRL_TB_EXT = 13; // timebase_source_select.
  localparam int CTRL_SMP_POL = 14; // Sample clock edge, 1 falling.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Default terminal selects: start 0, stop 1, A 2, B 3, index 4,
  // arm 5, sample clock 6, timebase 7 (three bits each).
  localparam logic [31:0] SELECT_RST = 32'h00FA_C688;
  localparam int SEL_W = 3; // Width of one terminal select.

  // Status register bits.
  localparam int ST_RUNNING = 0;
  localparam int ST_HELD = 1;
  localparam int ST_BUF_NE = 2;
  localparam int ST_OVF = 3;
  localparam int ST_ARMING = 4;

  // Selected signal slots.
  localparam int SIG_START = 0;
  localparam int SIG_STOP = 1;
  localparam int SIG_A = 2;
  localparam int SIG_B = 3;
  localparam int SIG_INDEX = 4;
  localparam int SIG_ARM = 5;
  localparam int SIG_SMP = 6;
  localparam int SIG_TB = 7;

  // Timing and decoding encodings.
  localparam logic [1:0] TIM_ON_DEMAND = 2'h0;
  localparam logic [1:0] TIM_IMPLICIT = 2'h1;
  localparam logic [1:0] TIM_SAMPLE = 2'h2;
  localparam logic [1:0] DEC_TWO_PULSE = 2'h0;
  localparam logic [1:0] DEC_SINGLE = 2'h1;
  localparam logic [1:0] DEC_DOUBLE = 2'h2;
  localparam logic [1:0] DEC_QUAD = 2'h3;

  // Phases of a measurement run.
  typedef enum logic [2:0] {
    RUN_STOPPED,
    RUN_ARMING,
    RUN_WAIT_START,
    RUN_COUNTING,
    RUN_HOLD
  } run_state_t;

endpackage : esec_pkg

// File: hdl/result_buf_if.sv
// Interface carrying results between the counter core and its buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface result_buf_if #(parameter int W = 32);
  logic push_valid; // A result is offered.
  logic push_ready; // Buffer has room.
  logic [W-1:0] push_data; // Offered result.
  logic pop_valid; // Buffer holds a result.
  logic pop_ready; // Consumer takes the head.
  logic [W-1:0] pop_data; // Head result.
  logic flush; // Empty the buffer.
  modport core (output push_valid, push_data, pop_ready, flush,
                input push_ready, pop_valid, pop_data);
  modport buffer (input push_valid, push_data, pop_ready, flush,
                  output push_ready, pop_valid, pop_data);
endinterface : result_buf_if
`default_nettype wire

// File: hdl/result_buf.sv
// Result buffer: a first-in first-out store of measurement results.
// Assumes DEPTH is a power of two and a single clock domain.
`timescale 1ns/100ps
`default_nettype none
module result_buf #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  result_buf_if.buffer bus
);
  localparam int AW = $clog2(DEPTH);

  // Whole buffer state, registered as one word.
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // Stored results.
    logic [AW-1:0] wp; // Write pointer.
    logic [AW-1:0] rp; // Read pointer.
    logic [AW:0] cnt; // Number of results held.
  } buf_state_t;

  buf_state_t s_reg;
  buf_state_t s_next;
  logic do_push;
  logic do_pop;

  // Full and empty come straight from the fill count.
  assign bus.push_ready = (s_reg.cnt != (AW + 1)'(DEPTH));
  assign bus.pop_valid = (s_reg.cnt != '0);
  assign bus.pop_data = s_reg.mem[s_reg.rp];

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // A push into a full buffer is refused; the core counts it as lost.
  always_comb begin
    s_next = s_reg;
    do_push = bus.push_valid & bus.push_ready;
    do_pop = bus.pop_ready & bus.pop_valid;
    if (do_push) begin
      s_next.mem[s_reg.wp] = bus.push_data;
      s_next.wp = s_reg.wp + AW'(1);
    end
    if (do_pop) begin
      s_next.rp = s_reg.rp + AW'(1);
    end
    if (do_push && !do_pop) begin
      s_next.cnt = s_reg.cnt + (AW + 1)'(1);
    end else if (do_pop && !do_push) begin
      s_next.cnt = s_reg.cnt - (AW + 1)'(1);
    end
    if (bus.flush) begin
      s_next.wp = '0;
      s_next.rp = '0;
      s_next.cnt = '0;
    end
  end

  // State register; reset clears the contents as well as the pointers and count.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg.mem <= '0;
      s_reg.wp <= '0;
      s_reg.rp <= '0;
      s_reg.cnt <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // result_buf
`default_nettype wire

// File: tb/esec_sva.sv
// Bus checks bound to the counter channel top module.
// Assumes one clock with a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module esec_sva
  import esec_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; cyc_i && stb_i && !ack_o; endsequence
  sequence rd_s; ack_o && !we_i; endsequence
  a_ack_pulse: assert property (req_s |=> ack_o ##1 !ack_o)
    else $error("ack pulse wrong");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_one_wait: assert property ($rose(cyc_i && stb_i) |-> !ack_o)
    else $error("ack too early");
  a_idle_quiet: assert property (!cyc_i |=> !ack_o)
    else $error("ack while idle");
  a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o)
    else $error("ack after reset");
  a_hole_zero: assert property ((rd_s and adr_i > 8'h18)
    |-> dat_o == 32'h0) else $error("unmapped read not zero");
  a_status_spare: assert property ((rd_s and adr_i == STATUS_OFS)
    |-> dat_o[31:5] == 27'h0) else $error("status spare bits set");
  a_select_spare: assert property ((rd_s and adr_i == SELECT_OFS)
    |-> dat_o[31:24] == 8'h0) else $error("select spare bits set");
endmodule // esec_sva
bind edge_separation_encoder_counter esec_sva chk_u (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o));
`default_nettype wire

// File: tb/edge_src_model.sv
// Model of the encoder and edge sources on the terminal pins.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module edge_src_model (
  input wire logic clk_i,
  output logic [7:0] pins_o
);
  initial pins_o = 8'h00;
  // Levels last two clocks or more, so the two-clock minimum is kept.
  task automatic hold(input int p, input logic v, input int c);
    pins_o[p] <= v;
    repeat (c) @(posedge clk_i);
  endtask
  // Start edge on pin 0, stop edge on pin 1, d clocks apart.
  task automatic pair(input int d);
    hold(0, 1'b1, d);
    hold(1, 1'b1, 4);
    rest;
  endtask
  // Every pin back to its idle low level for four clocks.
  task automatic rest;
    pins_o <= 8'h00;
    repeat (4) @(posedge clk_i);
  endtask
  // One quadrature cycle; phase A leads when f is set.
  task automatic quad(input bit f);
    hold(f ? 2 : 3, 1'b1, 4);
    hold(f ? 3 : 2, 1'b1, 4);
    hold(f ? 2 : 3, 1'b0, 4);
    hold(f ? 3 : 2, 1'b0, 4);
  endtask
endmodule // edge_src_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the counter channel.
// Assumes edge_src_model drives the terminal pins.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import esec_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic ack_o;
  wire logic [7:0] pins;
  int bad_count = 0, n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  edge_src_model pm_u (.clk_i(clk_i), .pins_o(pins));
  edge_separation_encoder_counter dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .programmable_function_terminal_i(pins));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // Classic cycle; read data is taken at the edge that sees ack.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string s);
    wb(0, a, 32'h0);
    chk(s, q, e);
  endtask
  // A low-then-high run bit is the software start.
  task automatic go(input logic [31:0] c);
    wb(1, CTRL_OFS, 32'h0);
    wb(1, CTRL_OFS, c);
  endtask
  task automatic t_reset;
    rd(CTRL_OFS, CTRL_RST, "ctrl");
    rd(SELECT_OFS, SELECT_RST, "select");
    wb(1, 8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0, "hole");
    sel_i <= 4'h3;
    wb(1, RELOAD_OFS, 32'hAAAA_BBBB);
    sel_i <= 4'hF;
    rd(RELOAD_OFS, 32'h0000_BBBB, "lanes");
  endtask
  task automatic t_sep;
    go(32'h0000_0001);
    pm_u.pair(10);
    pm_u.pair(7);
    rd(DATA_OFS, 32'h0000_000A, "held");
    pm_u.pair(5);
    rd(DATA_OFS, 32'h0000_0005, "next");
  endtask
  task automatic t_impl;
    go(32'h0000_0005);
    pm_u.pair(6);
    pm_u.pair(9);
    rd(DATA_OFS, 32'h0000_0006, "first");
    rd(DATA_OFS, 32'h0000_0009, "second");
    rd(DATA_OFS, 32'h0000_0000, "empty");
    repeat (17) pm_u.pair(3);
    wb(0, STATUS_OFS, 32'h0);
    chk("ovf", q & 32'h0000_0008, 32'h0000_0008);
  endtask
  task automatic t_pos;
    logic [31:0] k [4] = '{32'h0, 32'h1, 32'h2, 32'h4};
    wb(1, INIT_OFS, 32'h0000_0001);
    for (int d = 0; d < 4; d++) begin
      go(32'h0000_0003 | (32'(d) << 4));
      pm_u.quad(0);
      rd(COUNT_OFS, 32'h1 - k[d], "back");
      pm_u.quad(1);
      rd(COUNT_OFS, 32'h0000_0001, "fwd");
    end
  endtask
  task automatic t_idx;
    wb(1, RELOAD_OFS, 32'h0000_0055);
    go(32'h0000_0433);
    pm_u.hold(4, 1'b1, 8);
    pm_u.hold(4, 1'b0, 4);
    rd(COUNT_OFS, 32'h0000_0055, "reload");
    pm_u.quad(1);
    rd(COUNT_OFS, 32'h0000_0059, "resume");
  endtask
  // Armed, falling start, sample clock timing in separation mode.
  task automatic t_arm;
    go(32'h0000_0149);
    pm_u.pair(4);
    wb(0, STATUS_OFS, 32'h0);
    chk("arming", q & 32'h0000_0010, 32'h0000_0010);
    pm_u.hold(5, 1'b1, 4);
    pm_u.hold(6, 1'b1, 4);
    pm_u.hold(6, 1'b0, 4);
    pm_u.hold(0, 1'b1, 4);
    pm_u.hold(0, 1'b0, 6);
    pm_u.hold(1, 1'b1, 4);
    pm_u.hold(6, 1'b1, 4);
    pm_u.rest;
    rd(DATA_OFS, 32'h0000_0006, "sampled");
    rd(DATA_OFS, 32'h0000_0000, "one sample");
  endtask
  // External timebase: three rising edges between start and stop.
  task automatic t_tb;
    go(32'h0000_2005);
    pm_u.hold(0, 1'b1, 4);
    repeat (3) begin
      pm_u.hold(7, 1'b1, 2);
      pm_u.hold(7, 1'b0, 2);
    end
    pm_u.hold(1, 1'b1, 4);
    pm_u.rest;
    rd(DATA_OFS, 32'h0000_0003, "ext ticks");
  endtask
  // Position sampled once by the sample clock, then read in order.
  task automatic t_psmp;
    go(32'h0000_003B);
    pm_u.quad(1);
    pm_u.hold(6, 1'b1, 4);
    pm_u.hold(6, 1'b0, 4);
    pm_u.quad(1);
    rd(DATA_OFS, 32'h0000_0005, "pos sample");
    rd(DATA_OFS, 32'h0000_0000, "pos once");
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_reset;
    t_sep;
    t_impl;
    t_pos;
    t_idx;
    t_arm;
    t_tb;
    t_psmp;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
